//--- ubd_map.vh
/*
 Register offsets, field positions, reset values and timing
 constants of the baud, timeout, break and DMA signalling block.
 Assumes inclusion by bare name from the block's source files.
*/
`ifndef UBD_MAP_VH
`define UBD_MAP_VH

// Register byte addresses on the APB
`define UBD_OFS_DIV_LO      8'h00
`define UBD_OFS_DIV_HI      8'h04
`define UBD_OFS_LINE_CTRL   8'h08
`define UBD_OFS_MODEM_CTRL  8'h0c
`define UBD_OFS_FIFO_CTRL   8'h10
`define UBD_OFS_STATUS      8'h14

// Field positions
`define UBD_LC_WLEN_HI      1
`define UBD_LC_WLEN_LO      0
`define UBD_LC_BREAK        6
`define UBD_MC_PRESCALE     7
`define UBD_FC_FIFO_EN      0
`define UBD_FC_DMA_MODE     3
`define UBD_LS_FIFO_ERR     7
`define UBD_ST_TIMEOUT      0
`define UBD_ST_TX_RDY       1
`define UBD_ST_RX_RDY       2
`define UBD_ST_BAUD_ON      3

// Reset values
`define UBD_LC_RST          8'h1d
`define UBD_MC_RST          8'h00
`define UBD_FC_RST          8'h00

// Timing figures
`define UBD_TO_MULT         10'h004
`define UBD_TO_EXTRA        10'h00c
`define UBD_WLEN_BASE       10'h005
`define UBD_OVERSAMPLE_LOG2 4
`define UBD_PRESCALE_MAX    2'h3

`endif

//--- ubd_baud_gen.v
/*
 Prescaler and 16x baud tick generator.
 Assumes one clock, a divisor from registers and a reload pulse
 issued whenever software rewrites either divisor byte.
*/
`timescale 1ns/1ps
`include "ubd_map.vh"
`default_nettype none

module ubd_baud_gen #(
  parameter DIV_W = 16
) (
  input  wire             clock_in,
  input  wire             arst_n_in,
  input  wire [DIV_W-1:0] divisor_in,
  input  wire             prescale_in,
  input  wire             reload_in,
  output reg              tick_out
);

  reg  [1:0]       pre_cnt_q;
  reg  [DIV_W-1:0] div_cnt_q;
  wire             div_zero;
  wire             pre_en;

  assign div_zero = (divisor_in == {DIV_W{1'b0}});
  // Divide-by-four step only when the prescaler is selected
  assign pre_en   = prescale_in ? (pre_cnt_q == `UBD_PRESCALE_MAX) : 1'b1;

  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_cnt_q <= 2'h0;
      div_cnt_q <= {DIV_W{1'b0}};
      tick_out  <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (reload_in) begin
        // Fresh count so a new rate takes hold at once
        pre_cnt_q <= 2'h0;
        div_cnt_q <= div_zero ? {DIV_W{1'b0}} : divisor_in - 1'b1;
      end else if (div_zero) begin
        div_cnt_q <= {DIV_W{1'b0}};
      end else begin
        pre_cnt_q <= pre_cnt_q + 2'h1;
        if (pre_en) begin
          if (div_cnt_q == {DIV_W{1'b0}}) begin
            tick_out  <= 1'b1;
            div_cnt_q <= divisor_in - 1'b1;
          end else begin
            div_cnt_q <= div_cnt_q - 1'b1;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- ubd_core.v
/*
 Baud generator, receive timeout, break and DMA ready signalling
 of one UART channel, with an APB register slave.
 Assumes FIFO levels, trigger levels, FIFO strobes and the
 transmitter's serial bit come from logic on the same clock;
 the serial receive pin is asynchronous.
*/
// Function
// - Timeout when input high 4x char length plus 12 bits, FIFO non-empty.
// - Break-control bit 6 of line control forces serial output low.
// - Reference clock divided by integer divisor 1 to 65535.
// - Divider output runs at sixteen times the baud rate.
// - Modem control bit 7 inserts a divide-by-four prescaler.
// - Divisor kept as low and high byte; software writes both.
// - Divisor of zero produces no baud clock at all.
// - One baud tick times both transmitter and receiver.
// - FIFO control bit 3 selects DMA mode 0 or mode 1.
// - Mode 0 or FIFOs disabled gives single-character signalling.
// - Mode 1 gives block signalling, one request per several chars.
// - Single mode: transmit ready active when transmit path empty.
// - Single mode: transmit ready drops once a character is written.
// - Single mode: receive ready active while a character waits.
// - Single mode: receive ready drops when receiver is empty.
// - Block mode: transmit ready on trigger free spaces, off when full.
// - Block mode: receive ready on trigger or timeout, off on empty/error.
// - Divisor bytes keep their contents through reset.
`timescale 1ns/1ps
`include "ubd_map.vh"
`default_nettype none

module ubd_core #(
  parameter FIFO_DEPTH = 64,
  parameter LVL_W      = 7,
  parameter AW         = 8
) (
  input  wire             clock_in,
  input  wire             arst_n_in,
  // APB slave
  input  wire             psel_in,
  input  wire             penable_in,
  input  wire             pwrite_in,
  input  wire [AW-1:0]    paddr_in,
  input  wire [31:0]      pwdata_in,
  output reg  [31:0]      prdata_out,
  output reg              pready_out,
  output reg              pslverr_out,
  // Serial side
  input  wire             rx_serial_in,
  input  wire             tx_serial_in,
  output reg              tx_serial_out,
  // FIFO side of the channel
  input  wire [LVL_W-1:0] rx_level_in,
  input  wire [LVL_W-1:0] tx_level_in,
  input  wire [LVL_W-1:0] rx_trigger_in,
  input  wire [LVL_W-1:0] tx_trigger_in,
  input  wire             rx_fifo_read_in,
  input  wire             rx_fifo_write_in,
  input  wire             tx_fifo_write_in,
  input  wire [7:0]       line_status_in,
  // To transmitter, receiver and the host DMA
  output wire             baud16_tick_out,
  output reg              rx_timeout_out,
  output reg  [7:0]       line_control_out,
  output reg  [7:0]       modem_control_out,
  output reg  [7:0]       fifo_control_out,
  output reg              transmit_dma_ready_n_out,
  output reg              receive_dma_ready_n_out
);

  localparam [LVL_W-1:0] DEPTH_L = FIFO_DEPTH;
  localparam [LVL_W-1:0] LVL_0   = {LVL_W{1'b0}};

  // Bus decode
  reg  [7:0]  div_lo_q;
  reg  [7:0]  div_hi_q;
  reg  [31:0] rd_d;
  reg         err_d;
  wire        acc;
  wire        wr_en;
  wire        div_wr;
  wire [15:0] divisor;
  wire [7:0]  ofs;
  reg         div_wr_q;

  // Serial receive synchroniser
  reg         rx_meta_q;
  reg         rx_sync_q;

  // Timeout
  reg  [9:0]  to_cnt_q;
  wire [9:0]  wlen;
  wire [9:0]  to_bits;
  wire [9:0]  to_limit;
  wire        to_restart;
  wire        rx_empty;

  // DMA signalling
  wire        block_mode;
  wire [LVL_W:0] tx_free;
  reg         tx_rdy_d;
  reg         rx_rdy_d;
  reg         tx_rdy_q;
  reg         rx_rdy_q;

  assign ofs     = paddr_in[7:0];
  // Request is held until pready is seen, so act only on that edge
  assign acc     = psel_in & penable_in & pready_out;
  assign wr_en   = acc & pwrite_in;
  assign div_wr  = wr_en & ((ofs == `UBD_OFS_DIV_LO) | (ofs == `UBD_OFS_DIV_HI));
  assign divisor = {div_hi_q, div_lo_q};

  // Divisor bytes sit outside the reset so a channel keeps its rate
  always @(posedge clock_in) begin
    if (wr_en && (ofs == `UBD_OFS_DIV_LO)) begin
      div_lo_q <= pwdata_in[7:0];
    end
    if (wr_en && (ofs == `UBD_OFS_DIV_HI)) begin
      div_hi_q <= pwdata_in[7:0];
    end
  end

  // Reload one edge late so the divider loads the byte just written
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_wr_q <= 1'b0;
    end else begin
      div_wr_q <= div_wr;
    end
  end

  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      line_control_out  <= `UBD_LC_RST;
      modem_control_out <= `UBD_MC_RST;
      fifo_control_out  <= `UBD_FC_RST;
    end else if (wr_en) begin
      case (ofs)
        `UBD_OFS_LINE_CTRL: begin
          line_control_out <= pwdata_in[7:0];
        end
        `UBD_OFS_MODEM_CTRL: begin
          modem_control_out <= pwdata_in[7:0];
        end
        `UBD_OFS_FIFO_CTRL: begin
          fifo_control_out <= pwdata_in[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux and error answer for unmapped offsets
  always @* begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    case (ofs)
      `UBD_OFS_DIV_LO: begin
        rd_d[7:0] = div_lo_q;
      end
      `UBD_OFS_DIV_HI: begin
        rd_d[7:0] = div_hi_q;
      end
      `UBD_OFS_LINE_CTRL: begin
        rd_d[7:0] = line_control_out;
      end
      `UBD_OFS_MODEM_CTRL: begin
        rd_d[7:0] = modem_control_out;
      end
      `UBD_OFS_FIFO_CTRL: begin
        rd_d[7:0] = fifo_control_out;
      end
      `UBD_OFS_STATUS: begin
        rd_d[`UBD_ST_TIMEOUT] = rx_timeout_out;
        rd_d[`UBD_ST_TX_RDY]  = tx_rdy_q;
        rd_d[`UBD_ST_RX_RDY]  = rx_rdy_q;
        rd_d[`UBD_ST_BAUD_ON] = (divisor != 16'h0000);
      end
      default: begin
        err_d = 1'b1;
      end
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end else begin
      pready_out  <= psel_in & penable_in & ~pready_out;
      pslverr_out <= psel_in & penable_in & ~pready_out & err_d;
      if (psel_in && penable_in && !pready_out && !pwrite_in) begin
        prdata_out <= rd_d;
      end else begin
        prdata_out <= 32'h0000_0000;
      end
    end
  end

  // Single tick feeds both transmitter and receiver
  ubd_baud_gen #(
    .DIV_W (16)
  ) u_baud (
    .clock_in    (clock_in),
    .arst_n_in   (arst_n_in),
    .divisor_in  (divisor),
    .prescale_in (modem_control_out[`UBD_MC_PRESCALE]),
    .reload_in   (div_wr_q),
    .tick_out    (baud16_tick_out)
  );

  // Break overrides whatever the transmitter shifts out
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_serial_out <= 1'b1;
    end else if (line_control_out[`UBD_LC_BREAK]) begin
      tx_serial_out <= 1'b0;
    end else begin
      tx_serial_out <= tx_serial_in;
    end
  end

  // Pin is asynchronous; only the second stage is used
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= rx_serial_in;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Character length 5..8 bits from the word length field
  assign wlen     = `UBD_WLEN_BASE +
                    {8'h00, line_control_out[`UBD_LC_WLEN_HI:`UBD_LC_WLEN_LO]};
  assign to_bits  = (wlen * `UBD_TO_MULT) + `UBD_TO_EXTRA;
  assign to_limit = to_bits << `UBD_OVERSAMPLE_LOG2;
  assign rx_empty = (rx_level_in == LVL_0);
  assign to_restart = ~rx_sync_q | rx_fifo_read_in | rx_fifo_write_in | rx_empty;

  // Counts 16x ticks, so it stalls with the baud clock stopped
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      to_cnt_q       <= 10'h000;
      rx_timeout_out <= 1'b0;
    end else if (to_restart) begin
      to_cnt_q       <= 10'h000;
      rx_timeout_out <= 1'b0;
    end else if (to_cnt_q >= to_limit) begin
      rx_timeout_out <= 1'b1;
    end else if (baud16_tick_out) begin
      to_cnt_q <= to_cnt_q + 10'h001;
    end
  end

  // Block mode only with FIFOs on and mode bit set
  assign block_mode = fifo_control_out[`UBD_FC_DMA_MODE] &
                      fifo_control_out[`UBD_FC_FIFO_EN];
  assign tx_free    = {1'b0, DEPTH_L} - {1'b0, tx_level_in};

  always @* begin
    tx_rdy_d = tx_rdy_q;
    rx_rdy_d = rx_rdy_q;
    if (!block_mode) begin
      // Write strobe drops ready before the level has moved
      tx_rdy_d = (tx_level_in == LVL_0) & ~tx_fifo_write_in;
      rx_rdy_d = ~rx_empty;
    end else begin
      // Hysteresis between trigger and full gives burst requests
      if (tx_level_in >= DEPTH_L) begin
        tx_rdy_d = 1'b0;
      end else if (tx_free >= {1'b0, tx_trigger_in}) begin
        tx_rdy_d = 1'b1;
      end
      if (rx_empty || line_status_in[`UBD_LS_FIFO_ERR]) begin
        rx_rdy_d = 1'b0;
      end else if ((rx_level_in >= rx_trigger_in) || rx_timeout_out) begin
        rx_rdy_d = 1'b1;
      end
    end
  end

  // Pins are active low: transmit ready active, receive idle at reset
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_rdy_q                 <= 1'b1;
      rx_rdy_q                 <= 1'b0;
      transmit_dma_ready_n_out <= 1'b0;
      receive_dma_ready_n_out  <= 1'b1;
    end else begin
      tx_rdy_q                 <= tx_rdy_d;
      rx_rdy_q                 <= rx_rdy_d;
      transmit_dma_ready_n_out <= ~tx_rdy_d;
      receive_dma_ready_n_out  <= ~rx_rdy_d;
    end
  end

endmodule
`default_nettype wire

//--- ubd_core_props.sv
/*
 Checker for the ubd_core ports.
 Assumes a bind to ubd_core, one clock, async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ubd_core_props #(
  parameter FIFO_DEPTH = 64,
  parameter LVL_W      = 7
) (
  input wire logic             clock_in,
  input wire logic             arst_n_in,
  input wire logic             psel_in,
  input wire logic             penable_in,
  input wire logic             pready_out,
  input wire logic             tx_serial_in,
  input wire logic             tx_serial_out,
  input wire logic [7:0]       line_control_out,
  input wire logic [7:0]       fifo_control_out,
  input wire logic [LVL_W-1:0] rx_level_in,
  input wire logic [LVL_W-1:0] tx_level_in,
  input wire logic [LVL_W-1:0] rx_trigger_in,
  input wire logic             rx_fifo_read_in,
  input wire logic             rx_fifo_write_in,
  input wire logic             tx_fifo_write_in,
  input wire logic [7:0]       line_status_in,
  input wire logic             rx_timeout_out,
  input wire logic             transmit_dma_ready_n_out,
  input wire logic             receive_dma_ready_n_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  wire sgl      = !fifo_control_out[3] || !fifo_control_out[0];
  wire tx_empty = tx_level_in == 0 && !tx_fifo_write_in;
  wire rx_some  = rx_level_in != 0;
  wire rx_clr   = !rx_some || line_status_in[7];
  wire rx_hit   = rx_level_in >= rx_trigger_in || rx_timeout_out;
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_access;
    psel_in && penable_in && !pready_out;
  endsequence
  a_apb_wait: assert property (s_setup ##1 s_access |=> pready_out)
    else $error("pready missing in second access cycle");
  a_break_low: assert property (line_control_out[6] |=> !tx_serial_out)
    else $error("break set but serial output high");
  a_serial_follow: assert property (!line_control_out[6] |=>
    tx_serial_out == $past(tx_serial_in)) else $error("serial output not following");
  a_tx_single: assert property (sgl |=> transmit_dma_ready_n_out == !$past(tx_empty))
    else $error("single transmit ready wrong");
  a_rx_single: assert property (sgl |=> receive_dma_ready_n_out == !$past(rx_some))
    else $error("single receive ready wrong");
  a_tx_block_full: assert property (!sgl && tx_level_in >= FIFO_DEPTH |=> transmit_dma_ready_n_out)
    else $error("block transmit ready active when full");
  a_rx_block_set: assert property (!sgl && !rx_clr && rx_hit |=> !receive_dma_ready_n_out)
    else $error("block receive ready not set");
  a_rx_block_clr: assert property (!sgl && rx_clr |=> receive_dma_ready_n_out)
    else $error("block receive ready not cleared");
  a_timeout_restart: assert property (rx_fifo_read_in || rx_fifo_write_in |=> !rx_timeout_out)
    else $error("timeout not cleared by strobe");
  a_timeout_empty: assert property (!rx_some |=> !rx_timeout_out)
    else $error("timeout with empty receive FIFO");
endmodule
`default_nettype wire

//--- ubd_fifo_model.sv
/*
 Fill-level model of the channel FIFOs facing the block.
 Assumes one-cycle push and pop requests from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module ubd_fifo_model (
  input  wire logic       clock_in,
  input  wire logic       arst_n_in,
  input  wire logic       rx_push_in,
  input  wire logic       rx_pop_in,
  input  wire logic       tx_push_in,
  input  wire logic       tx_pop_in,
  output var  logic [6:0] rx_level_out,
  output var  logic [6:0] tx_level_out
);
  // No saturation: the bench never overfills
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_level_out <= 7'h00;
      tx_level_out <= 7'h00;
    end else begin
      rx_level_out <= rx_level_out + 7'(rx_push_in) - 7'(rx_pop_in);
      tx_level_out <= tx_level_out + 7'(tx_push_in) - 7'(tx_pop_in);
    end
  end
endmodule
`default_nettype wire

//--- ubd_core_tb.sv
/*
 Self-checking bench for ubd_core over APB with a FIFO model.
 Assumes one wait state and 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  tests_run++; \
  if ((a) !== (b)) begin \
    fails++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, b); \
  end \
end
module ubd_core_tb;
  localparam int TO = (4 * 6 + 12) * 16;
  logic        clock_in = 1'b0;
  logic        arst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, err, tx_out, tick, tmo, txr_n, rxr_n;
  logic        tx_in = 1'b1;
  logic        rx_pin = 1'b1;
  logic [7:0]  lco, mco, fco;
  logic [3:0]  strb = 4'h0;
  logic [7:0]  line_status = 8'h00;
  logic [6:0]  rxl, txl;
  int          fails = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          k;
  ubd_core uut (.clock_in(clock_in), .arst_n_in(arst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .rx_serial_in(rx_pin), .tx_serial_in(tx_in), .tx_serial_out(tx_out),
    .rx_level_in(rxl), .tx_level_in(txl), .rx_trigger_in(7'd4), .tx_trigger_in(7'd8),
    .rx_fifo_read_in(strb[1]), .rx_fifo_write_in(strb[0]), .tx_fifo_write_in(strb[2]),
    .line_status_in(line_status), .baud16_tick_out(tick), .rx_timeout_out(tmo),
    .line_control_out(lco), .modem_control_out(mco), .fifo_control_out(fco),
    .transmit_dma_ready_n_out(txr_n), .receive_dma_ready_n_out(rxr_n));
  ubd_fifo_model u_fifo (.clock_in(clock_in), .arst_n_in(arst_n), .rx_push_in(strb[0]),
    .rx_pop_in(strb[1]), .tx_push_in(strb[2]), .tx_pop_in(strb[3]),
    .rx_level_out(rxl), .tx_level_out(txl));
  always #5 clock_in = ~clock_in;
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      print_verdict;
    end
  end
  // No sleep mode here, so divisor writes are always legal
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do @(posedge clock_in); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic st(input logic [3:0] m);
    @(posedge clock_in);
    strb <= m;
    @(posedge clock_in);
    strb <= 4'h0;
    repeat (2) @(negedge clock_in);
  endtask
  // Skips a stale tick from before the reload
  task automatic per(output int n);
    int w;
    w = 0;
    n = 0;
    repeat (2) @(negedge clock_in);
    while (tick !== 1'b1 && w < 2000) begin
      @(negedge clock_in);
      w++;
    end
    do begin
      @(negedge clock_in);
      n++;
    end while (tick !== 1'b1 && n < 2000);
  endtask
  initial begin
    repeat (20) @(posedge clock_in);
    arst_n <= 1'b1;
    apb(0, 8'h08, 0); `CHK(rdat, 32'h1d)
    apb(0, 8'h0c, 0); `CHK(rdat, 32'h0)
    apb(0, 8'h10, 0); `CHK(rdat, 32'h0)
    apb(0, 8'h18, 0); `CHK({err, rdat}, 33'h1_0000_0000)
    $display("test regs done");
    apb(1, 8'h04, 32'h00);
    apb(1, 8'h00, 32'h03);
    per(k); `CHK(k, 3)
    apb(1, 8'h0c, 32'h80);
    per(k); `CHK(k, 12)
    `CHK(mco, 8'h80)
    apb(1, 8'h0c, 32'h00);
    apb(1, 8'h04, 32'h01);
    apb(1, 8'h00, 32'h00);
    per(k); `CHK(k, 256)
    repeat (3) @(posedge clock_in);
    arst_n <= 1'b0;
    repeat (20) @(posedge clock_in);
    arst_n <= 1'b1;
    per(k); `CHK(k, 256)
    apb(0, 8'h14, 0); `CHK(rdat[3], 1'b1)
    apb(1, 8'h04, 32'h00);
    per(k); `CHK(k, 2000)
    apb(0, 8'h14, 0); `CHK(rdat[3], 1'b0)
    apb(1, 8'h00, 32'h01);
    per(k); `CHK(k, 1)
    $display("test baud done");
    apb(1, 8'h08, 32'h5d);
    repeat (2) @(negedge clock_in);
    `CHK(tx_out, 1'b0)
    `CHK(lco, 8'h5d)
    apb(1, 8'h08, 32'h1d);
    repeat (2) @(negedge clock_in);
    `CHK(tx_out, 1'b1)
    @(posedge clock_in);
    tx_in <= 1'b0;
    repeat (2) @(negedge clock_in);
    `CHK(tx_out, 1'b0)
    @(posedge clock_in);
    tx_in <= 1'b1;
    $display("test break done");
    `CHK({txr_n, rxr_n}, 2'b01)
    st(4'h4); `CHK(txr_n, 1'b1)
    st(4'h8); `CHK(txr_n, 1'b0)
    apb(1, 8'h10, 32'h08);
    st(4'h1); `CHK(rxr_n, 1'b0)
    st(4'h2); `CHK(rxr_n, 1'b1)
    $display("test single done");
    apb(1, 8'h10, 32'h09);
    repeat (2) @(negedge clock_in);
    `CHK(txr_n, 1'b0)
    `CHK(fco, 8'h09)
    repeat (64) st(4'h4);
    `CHK(txr_n, 1'b1)
    repeat (7) st(4'h8);
    `CHK(txr_n, 1'b1)
    st(4'h8); `CHK(txr_n, 1'b0)
    repeat (3) st(4'h1);
    `CHK(rxr_n, 1'b1)
    st(4'h1); `CHK(rxr_n, 1'b0)
    @(posedge clock_in);
    line_status <= 8'h80;
    repeat (2) @(negedge clock_in);
    `CHK(rxr_n, 1'b1)
    @(posedge clock_in);
    line_status <= 8'h00;
    repeat (4) st(4'h2);
    `CHK(rxr_n, 1'b1)
    st(4'h1);
    // A short low on the receive pin must restart the count
    repeat (100) @(posedge clock_in);
    rx_pin <= 1'b0;
    @(posedge clock_in);
    rx_pin <= 1'b1;
    k = 0;
    while (tmo !== 1'b1 && k < 2000) begin
      @(negedge clock_in);
      k++;
    end
    `CHK(k >= TO && k <= TO + 4, 1'b1)
    repeat (2) @(negedge clock_in);
    `CHK(rxr_n, 1'b0)
    apb(0, 8'h14, 0); `CHK(rdat[3:0], 4'hf)
    st(4'h2); `CHK({tmo, rxr_n}, 2'b01)
    $display("test block done");
    print_verdict;
  end
endmodule
bind ubd_core ubd_core_props #(.FIFO_DEPTH(FIFO_DEPTH), .LVL_W(LVL_W)) u_props (
  .clock_in(clock_in), .arst_n_in(arst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pready_out(pready_out), .tx_serial_in(tx_serial_in), .tx_serial_out(tx_serial_out),
  .line_control_out(line_control_out), .fifo_control_out(fifo_control_out),
  .rx_level_in(rx_level_in), .tx_level_in(tx_level_in), .rx_trigger_in(rx_trigger_in),
  .rx_fifo_read_in(rx_fifo_read_in), .rx_fifo_write_in(rx_fifo_write_in),
  .tx_fifo_write_in(tx_fifo_write_in), .line_status_in(line_status_in),
  .rx_timeout_out(rx_timeout_out), .transmit_dma_ready_n_out(transmit_dma_ready_n_out),
  .receive_dma_ready_n_out(receive_dma_ready_n_out));
`default_nettype wire
